//--- include/wdit_regs.svh
// Register offsets, field positions, reset values and keys of the watchdog interval timer
`ifndef WDIT_REGS_SVH
`define WDIT_REGS_SVH

// Register byte addresses; the decoder looks at the low 16 bits only
`define WDIT_CNT_IDX        32'hFFFF_E810
`define WDIT_CSR_IDX        32'hFFFF_E812

// Reset values
`define WDIT_CNT_RST        8'h00
`define WDIT_CSR_RST        8'h00

// Write keys carried in the upper byte of a 16-bit write
`define WDIT_CNT_KEY        8'h5A
`define WDIT_CSR_KEY        8'hA5

// Control/status field positions
`define WDIT_RUN_BIT        7
`define WDIT_MODE_BIT       6
`define WDIT_RSTTYPE_BIT    5
`define WDIT_WATCHDOG_OVERFLOW_FLAG_BIT       4
`define WDIT_INTERVAL_OVERFLOW_FLAG_BIT       3
`define WDIT_CKS_LSB        0
`define WDIT_CKS_W          3

// Counter width and its all-ones value
`define WDIT_CNT_W          8
`define WDIT_CNT_MAX        8'hFF

// Prescaler shift per clock choice, choice 7 in the top nibble
`define WDIT_DIV_SHIFTS     32'hC_A98_7650
`define WDIT_DIV_W          12
`define WDIT_NSEL           8

`endif

//--- include/wdit_pkg.sv
// Types shared by the watchdog interval timer modules
`default_nettype none
package wdit_pkg;

	// Control/status register layout
	typedef struct packed {
		logic       countRun;
		logic       modeSelect;
		logic       resetType;
		logic       watchdogOverflowFlag;
		logic       intervalOverflowFlag;
		logic [2:0] countClockSelect;
	} wdit_csr_t;

	// Counting state, one-hot
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b001,
		ST_RUN    = 3'b010,
		ST_SETTLE = 3'b100
	} wdit_state_t;

endpackage
`default_nettype wire

//--- hw/wdit_prescaler.sv
// Free-running prescaler giving one count tick per selected division of mclk
`timescale 1ns/1ns
`default_nettype none
`include "wdit_regs.svh"

module wdit_prescaler
	import wdit_pkg::*;
#(
	parameter int                          NSEL   = `WDIT_NSEL,
	parameter int                          DIV_W  = `WDIT_DIV_W,
	parameter logic [4*`WDIT_NSEL-1:0]     SHIFTS = `WDIT_DIV_SHIFTS
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             arst_n,
	// Selection and tick
	input  wire logic [2:0]       countClockSelect,
	output logic                  countTick
);

	logic [DIV_W-1:0] divider_ff;
	logic [NSEL-1:0]  tickAll;

	// Divider runs on every edge from reset onward
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			divider_ff <= '0;
		end else begin
			divider_ff <= divider_ff + 1'b1;
		end
	end

	// One tick decoder per clock choice
	genvar g;
	generate
		for (g = 0; g < NSEL; g++) begin : gTick
			localparam logic [DIV_W:0] FULL = (DIV_W+1)'(1) << SHIFTS[4*g +: 4];
			localparam logic [DIV_W-1:0] MASK = DIV_W'(FULL - (DIV_W+1)'(1));
			assign tickAll[g] = ((divider_ff & MASK) == MASK);
		end
	endgenerate

	// Selected tick
	assign countTick = tickAll[countClockSelect];

endmodule
`default_nettype wire

//--- hw/wdit_watchdog_interval_timer.sv
// Watchdog and interval timer with classic Wishbone register access
`timescale 1ns/1ns
`default_nettype none
`include "wdit_regs.svh"

// Behaviour
// - One timer channel counting a clock derived from mclk.
// - Timer can count oscillator settling after leaving software standby.
// - Two modes selectable: watchdog and interval timer.
// - Watchdog mode overflow raises an internal chip reset request.
// - Interval mode overflow raises an interrupt request and no reset.
// - Eight count clocks from undivided down to one 4096th of mclk.
// - Watchdog reset is either power-on or manual reset.
// - Watchdog overflow drives the overflow pin low one count clock period.
// - 8-bit read/write counter increments on each selected count tick.
// - Counter keeps its value through its own internal reset.
// - Counter cleared to zero only by the external power-on reset.
// - Counter and control/status decoded at adjacent addresses, reset zero.
// - Control bit 7 starts and stops counting; stopped counter holds.
// - Control bit 6 selects mode: 0 interval, 1 watchdog.
// - Control bit 5 selects power-on or manual reset, ignored in interval.
// - Status bit 4 flags watchdog overflow, bit 3 interval overflow.
module wdit_watchdog_interval_timer
	import wdit_pkg::*;
(
	// Clock and external power-on reset
	input  wire logic        mclk,
	input  wire logic        arst_n,
	// Classic Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [15:0] adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic [31:0]      dat_o,
	output logic             ack_o,
	// Standby exit settling request, same clock domain
	input  wire logic        standbySettleStart,
	output logic             standbySettleDone,
	// Overflow pin and chip-level requests
	output logic             overflowPulsePin_n,
	output logic             powerOnResetReq,
	output logic             manualResetReq,
	output logic             intervalIrq
);

	// Register byte addresses, two adjacent even places; low 16 bits decoded
	localparam logic [31:0] CNT_FULL = `WDIT_CNT_IDX;
	localparam logic [31:0] CSR_FULL = `WDIT_CSR_IDX;
	localparam logic [15:0] CNT_ADR  = CNT_FULL[15:0];
	localparam logic [15:0] CSR_ADR  = CSR_FULL[15:0];

	logic [`WDIT_CNT_W-1:0] watchdogCounter_ff;
	wdit_csr_t              watchdogControlStatus_ff;
	wdit_state_t            state_ff;
	wdit_state_t            nxt_state;
	logic                   ack_ff;
	logic [31:0]            rdData_ff;
	logic                   pinLow_ff;
	logic                   pinReset_ff;
	logic                   irq_ff;
	logic                   settleDone_ff;

	logic                   countTick;
	logic                   busReq;
	logic                   busWrite;
	logic                   hitCnt;
	logic                   hitCsr;
	logic                   wordAccess;
	logic                   cntWrite;
	logic                   csrWrite;
	logic                   countEn;
	logic                   countStep;
	logic                   wrap;
	logic                   wdOverflow;
	logic                   itOverflow;
	logic                   settleOverflow;

	// Prescaler with eight count clock choices
	wdit_prescaler #(
		.NSEL   (`WDIT_NSEL),
		.DIV_W  (`WDIT_DIV_W),
		.SHIFTS (`WDIT_DIV_SHIFTS)
	) uPrescaler (
		.mclk             (mclk),
		.arst_n           (arst_n),
		.countClockSelect (watchdogControlStatus_ff.countClockSelect),
		.countTick        (countTick)
	);

	// Bus decode; both registers use the low lane, dat bits 15:0 and sel bits 1:0
	assign busReq     = cyc_i && stb_i && !ack_ff;
	assign busWrite   = cyc_i && stb_i && ack_ff && we_i;
	assign hitCnt     = (adr_i[15:1] == CNT_ADR[15:1]);
	assign hitCsr     = (adr_i[15:1] == CSR_ADR[15:1]);
	assign wordAccess = (sel_i[1:0] == 2'b11);

	// Keyed word writes only; anything else leaves the registers alone
	assign cntWrite = busWrite && hitCnt && wordAccess
		&& (dat_i[15:8] == `WDIT_CNT_KEY);
	assign csrWrite = busWrite && hitCsr && wordAccess
		&& (dat_i[15:8] == `WDIT_CSR_KEY);

	// Counting and overflow classification
	assign countEn        = (state_ff != ST_IDLE);
	assign countStep      = countTick && countEn && !cntWrite;
	assign wrap           = countStep && (watchdogCounter_ff == `WDIT_CNT_MAX);
	assign settleOverflow = wrap && (state_ff == ST_SETTLE);
	assign wdOverflow     = wrap && (state_ff == ST_RUN)
		&& watchdogControlStatus_ff.modeSelect;
	assign itOverflow     = wrap && (state_ff == ST_RUN)
		&& !watchdogControlStatus_ff.modeSelect;

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= busReq;
		end
	end

	// Read data captured at request; unmapped reads return zero
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdData_ff <= 32'h0000_0000;
		end else if (busReq) begin
			if (hitCnt) begin
				rdData_ff <= {24'h00_0000, watchdogCounter_ff};
			end else if (hitCsr) begin
				rdData_ff <= {24'h00_0000, watchdogControlStatus_ff};
			end else begin
				rdData_ff <= 32'h0000_0000;
			end
		end
	end

	assign ack_o = ack_ff;
	assign dat_o = rdData_ff;

	// Counting state
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (watchdogControlStatus_ff.countRun) begin
					nxt_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!watchdogControlStatus_ff.countRun) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_SETTLE: begin
				if (settleOverflow) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		if (standbySettleStart) begin
			nxt_state = ST_SETTLE;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Counter; only the external reset clears it, its own reset request never does
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			watchdogCounter_ff <= `WDIT_CNT_RST;
		end else if (cntWrite) begin
			watchdogCounter_ff <= dat_i[7:0];
		end else if (countStep) begin
			watchdogCounter_ff <= watchdogCounter_ff + 8'h01;
		end
	end

	// Control fields written by keyed word write
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			watchdogControlStatus_ff.countRun         <= 1'b0;
			watchdogControlStatus_ff.modeSelect       <= 1'b0;
			watchdogControlStatus_ff.resetType        <= 1'b0;
			watchdogControlStatus_ff.countClockSelect <= 3'h0;
		end else if (csrWrite) begin
			watchdogControlStatus_ff.countRun         <= dat_i[`WDIT_RUN_BIT];
			watchdogControlStatus_ff.modeSelect       <= dat_i[`WDIT_MODE_BIT];
			watchdogControlStatus_ff.resetType        <= dat_i[`WDIT_RSTTYPE_BIT];
			watchdogControlStatus_ff.countClockSelect <=
				dat_i[`WDIT_CKS_LSB +: `WDIT_CKS_W];
		end
	end

	// Overflow flags: hardware set wins, writing 0 clears, writing 1 keeps
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			watchdogControlStatus_ff.watchdogOverflowFlag <= 1'b0;
			watchdogControlStatus_ff.intervalOverflowFlag <= 1'b0;
		end else begin
			watchdogControlStatus_ff.watchdogOverflowFlag <= wdOverflow
				|| (watchdogControlStatus_ff.watchdogOverflowFlag
				&& !(csrWrite && !dat_i[`WDIT_WATCHDOG_OVERFLOW_FLAG_BIT]));
			watchdogControlStatus_ff.intervalOverflowFlag <= itOverflow
				|| (watchdogControlStatus_ff.intervalOverflowFlag
				&& !(csrWrite && !dat_i[`WDIT_INTERVAL_OVERFLOW_FLAG_BIT]));
		end
	end

	// Overflow pin low from overflow until the next count tick
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pinLow_ff   <= 1'b0;
			pinReset_ff <= 1'b0;
		end else if (wdOverflow) begin
			pinLow_ff   <= 1'b1;
			pinReset_ff <= watchdogControlStatus_ff.resetType;
		end else if (countTick) begin
			pinLow_ff   <= 1'b0;
		end
	end

	assign overflowPulsePin_n = !pinLow_ff;
	assign powerOnResetReq    = pinLow_ff && !pinReset_ff;
	assign manualResetReq     = pinLow_ff && pinReset_ff;

	// Interval interrupt pulse and settling completion pulse
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			irq_ff        <= 1'b0;
			settleDone_ff <= 1'b0;
		end else begin
			irq_ff        <= itOverflow;
			settleDone_ff <= settleOverflow;
		end
	end

	assign intervalIrq       = irq_ff;
	assign standbySettleDone = settleDone_ff;

	// Checks of the timer behaviour
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);

	a_ack_one_cycle: assert property (
		busReq |=> ack_o ##1 !ack_o
	) else $error("ack not a single cycle after request");

	a_cnt_run_hold: assert property (
		(state_ff == ST_IDLE) && !cntWrite && !standbySettleStart
			|=> $stable(watchdogCounter_ff)
	) else $error("stopped counter changed");

	a_cnt_step_incr: assert property (
		countStep |=> watchdogCounter_ff == 8'($past(watchdogCounter_ff) + 8'h01)
	) else $error("counter did not step by one");

	a_cnt_key_reject: assert property (
		busWrite && hitCnt && ((dat_i[15:8] != `WDIT_CNT_KEY) || !wordAccess) && !countStep
			|=> $stable(watchdogCounter_ff)
	) else $error("unkeyed counter write took effect");

	a_wd_pin_low: assert property (
		wdOverflow |=> !overflowPulsePin_n && (powerOnResetReq || manualResetReq)
	) else $error("watchdog overflow without low pin and reset");

	a_wd_pin_release: assert property (
		!overflowPulsePin_n && countTick && !wdOverflow |=> overflowPulsePin_n
	) else $error("overflow pin not released at next tick");

	a_rst_type_sel: assert property (
		wdOverflow && watchdogControlStatus_ff.resetType |=> manualResetReq && !powerOnResetReq
	) else $error("manual reset type not honoured");

	a_it_irq_noreset: assert property (
		itOverflow && overflowPulsePin_n
			|=> intervalIrq && overflowPulsePin_n
			&& watchdogControlStatus_ff.intervalOverflowFlag
	) else $error("interval overflow misbehaved");

	a_wd_flag_only: assert property (
		wdOverflow |=> watchdogControlStatus_ff.watchdogOverflowFlag
			&& !intervalIrq
	) else $error("watchdog flag not set alone");

	a_wrap_to_zero: assert property (
		wrap |=> (watchdogCounter_ff == 8'h00)
	) else $error("overflow did not wrap to zero");

	a_settle_done: assert property (
		settleOverflow |=> standbySettleDone && (state_ff == ST_IDLE)
			&& overflowPulsePin_n && !intervalIrq
	) else $error("settling overflow handled wrongly");

	a_cnt_write_val: assert property (
		cntWrite |=> watchdogCounter_ff == $past(dat_i[7:0])
	) else $error("keyed counter write lost");

	a_rst_type_por: assert property (
		wdOverflow && !watchdogControlStatus_ff.resetType
			|=> powerOnResetReq && !manualResetReq
	) else $error("power-on reset type not honoured");

	a_it_no_reset: assert property (
		itOverflow && overflowPulsePin_n
			|=> !powerOnResetReq && !manualResetReq
	) else $error("interval overflow requested a reset");

	a_it_flag_only: assert property (
		itOverflow && !csrWrite |=> watchdogControlStatus_ff.intervalOverflowFlag
			&& $stable(watchdogControlStatus_ff.watchdogOverflowFlag)
	) else $error("interval flag not set alone");

	a_flag_clear: assert property (
		csrWrite && !dat_i[`WDIT_WATCHDOG_OVERFLOW_FLAG_BIT] && !wdOverflow
			|=> !watchdogControlStatus_ff.watchdogOverflowFlag
	) else $error("watchdog flag not cleared by zero write");

	a_run_start: assert property (
		(state_ff == ST_IDLE) && csrWrite && dat_i[`WDIT_RUN_BIT] && !standbySettleStart
			##1 !standbySettleStart |=> (state_ff == ST_RUN)
	) else $error("run bit did not start counting");

	a_read_cnt_data: assert property (
		busReq && hitCnt |=> dat_o == {24'h00_0000, $past(watchdogCounter_ff)}
	) else $error("counter read data wrong");

	a_settle_no_flag: assert property (
		settleOverflow && !csrWrite |=> $stable(watchdogControlStatus_ff)
	) else $error("settling overflow touched control");

endmodule
`default_nettype wire

//--- test/wdit_watchdog_interval_timer_tb.sv
// Self-checking bench for the watchdog interval timer
`timescale 1ns/1ns
`default_nettype none
`include "wdit_regs.svh"

module wdit_watchdog_interval_timer_tb
	import wdit_pkg::*;
;
	localparam logic [15:0] ADR_CNT = 16'hE810;
	localparam logic [15:0] ADR_CSR = 16'hE812;
	localparam logic [15:0] ADR_BAD = 16'hE814;

	logic        mclk, arst_n, cyc_i, stb_i, we_i, ack_o;
	logic [15:0] adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i, dat_o, rdData;
	logic        standbySettleStart, standbySettleDone;
	logic        overflowPulsePin_n, powerOnResetReq, manualResetReq, intervalIrq;
	int          errors, compares, lowCycles, div;

	wdit_watchdog_interval_timer wdit_watchdog_interval_timer_i (
		.mclk(mclk), .arst_n(arst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.standbySettleStart(standbySettleStart), .standbySettleDone(standbySettleDone),
		.overflowPulsePin_n(overflowPulsePin_n), .powerOnResetReq(powerOnResetReq),
		.manualResetReq(manualResetReq), .intervalIrq(intervalIrq)
	);

	// Clock at 50 MHz
	always #10 mclk = ~mclk;

	// Verdict and end of run
	task automatic wrap_up();
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Compare seen against expected
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One classic Wishbone cycle, held until ack is sampled
	task automatic xfer(input logic [15:0] a, input logic w, input logic [3:0] s,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		sel_i <= s;
		dat_i <= d;
		do begin
			@(posedge mclk);
			n++;
		end while (ack_o !== 1'b1 && n < 50);
		rdData = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
		if (n >= 50) begin
			errors++;
			wrap_up();
		end
	endtask

	// Byte read
	task automatic rd(input logic [15:0] a);
		xfer(a, 1'b0, 4'h1, 32'h0000_0000);
	endtask

	// Counter write with chosen key and byte enables
	task automatic wrCnt(input logic [7:0] v, input logic [7:0] key, input logic [3:0] s);
		xfer(ADR_CNT, 1'b1, s, {16'h0000, key, v});
	endtask

	// Keyed control/status write
	task automatic wrCsr(input logic [7:0] v);
		xfer(ADR_CSR, 1'b1, 4'h3, {16'h0000, 8'(`WDIT_CSR_KEY), v});
	endtask

	// Bounded wait: 0 pin low, 1 interval pulse, 2 settling done
	task automatic waitEvt(input int which, input int bound);
		int   n;
		logic hit;
		n = 0;
		hit = 1'b0;
		while (!hit && n < bound) begin
			@(posedge mclk);
			n++;
			hit = (which == 0) ? (overflowPulsePin_n === 1'b0) :
				(which == 1) ? (intervalIrq === 1'b1) : (standbySettleDone === 1'b1);
		end
		if (!hit) begin
			errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
			wrap_up();
		end
	endtask

	// Main sequence
	initial begin
		mclk = 1'b0;
		arst_n = 1'b0;
		{cyc_i, stb_i, we_i, standbySettleStart} = 4'h0;
		adr_i = 16'h0000;
		sel_i = 4'h0;
		dat_i = 32'h0000_0000;
		errors = 0;
		compares = 0;
		repeat (10) @(posedge mclk);
		arst_n <= 1'b1;
		// Reset values and an unmapped place
		rd(ADR_CNT);
		check(rdData, 32'h0000_0000);
		rd(ADR_CSR);
		check(rdData, 32'h0000_0000);
		rd(ADR_BAD);
		check(rdData, 32'h0000_0000);
		// Keyed write, then wrong key and byte-wide write
		wrCnt(8'h37, `WDIT_CNT_KEY, 4'h3);
		rd(ADR_CNT);
		check(rdData, 32'h0000_0037);
		wrCnt(8'h55, 8'h5B, 4'h3);
		rd(ADR_CNT);
		check(rdData, 32'h0000_0037);
		wrCnt(8'h55, `WDIT_CNT_KEY, 4'h1);
		rd(ADR_CNT);
		check(rdData, 32'h0000_0037);
		// Interval overflow with reset type set: pulse, flag, no reset
		wrCnt(8'hFE, `WDIT_CNT_KEY, 4'h3);
		wrCsr(8'hA0);
		waitEvt(1, 20);
		check({overflowPulsePin_n, powerOnResetReq, manualResetReq}, 3'b100);
		check({powerOnResetReq, manualResetReq}, 2'b00);
		@(posedge mclk);
		check(intervalIrq, 1'b0);
		rd(ADR_CSR);
		check(rdData, 32'h0000_00A8);
		// Stopped counter holds
		wrCsr(8'h00);
		wrCnt(8'h10, `WDIT_CNT_KEY, 4'h3);
		repeat (20) @(posedge mclk);
		rd(ADR_CNT);
		check(rdData, 32'h0000_0010);
		rd(ADR_CSR);
		check(rdData, 32'h0000_0000);
		// Watchdog overflow over every clock choice and both reset types
		for (int k = 0; k < 8; k++) begin
			div = 1 << ((`WDIT_DIV_SHIFTS >> (4 * k)) & 15);
			wrCsr(8'h00);
			wrCnt(8'hFF, `WDIT_CNT_KEY, 4'h3);
			wrCsr(8'hC0 | 8'(k[0] << 5) | 8'(k));
			waitEvt(0, div + 20);
			check({powerOnResetReq, manualResetReq}, k[0] ? 2'b01 : 2'b10);
			lowCycles = 0;
			while (overflowPulsePin_n === 1'b0 && lowCycles <= div) begin
				lowCycles++;
				@(posedge mclk);
			end
			check(lowCycles, div);
			rd(ADR_CSR);
			check(rdData, 32'h0000_00D0 | (k[0] << 5) | k);
		end
		// Settling count after standby runs without the run bit
		wrCsr(8'h00);
		wrCnt(8'hF0, `WDIT_CNT_KEY, 4'h3);
		@(posedge mclk);
		standbySettleStart <= 1'b1;
		@(posedge mclk);
		standbySettleStart <= 1'b0;
		waitEvt(2, 40);
		rd(ADR_CSR);
		check(rdData, 32'h0000_0000);
		rd(ADR_CNT);
		check(rdData, 32'h0000_0000);
		// External reset clears counter and control
		wrCnt(8'h44, `WDIT_CNT_KEY, 4'h3);
		wrCsr(8'h80);
		@(posedge mclk);
		arst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		rd(ADR_CNT);
		check(rdData, 32'h0000_0000);
		rd(ADR_CSR);
		check(rdData, 32'h0000_0000);
		wrap_up();
	end
endmodule
`default_nettype wire
